// [hdl/arm_regbank.sv]
// Purpose: Serial-port register bank with shadowed configuration and transfer
// Assumes: Serial clock far slower than sys_clk; mode 0 sampling on rising SCLK
// Notes: Chip-select high mid-byte resets the frame state
`default_nettype none
module arm_regbank
    import arm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Serial port pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe,
    // Active configuration
    output logic lsb_first,
    output logic soft_reset,
    output logic [3:0] channel_write_mask,
    output logic [1:0] power_state,
    output logic powered_down,
    output logic chip_in_reset,
    output logic stabilizer_en,
    output logic [3:0] input_set_select,
    output logic keep_unused_on,
    output logic [4:0] channels_active
);
    typedef enum {ST_IDLE, ST_INSTR, ST_DATA} arm_state_t;

    // ===========================================================
    // Pin synchronisation
    logic sclk_s, cs_n_s, sdio_s;
    arm_pin_sync u_sync_clk (.sys_clk(sys_clk), .srst(srst), .pin_in(sclk), .level_out(sclk_s));
    arm_pin_sync u_sync_cs (.sys_clk(sys_clk), .srst(srst), .pin_in(cs_n), .level_out(cs_n_s));
    arm_pin_sync u_sync_dat (.sys_clk(sys_clk), .srst(srst), .pin_in(sdio_i), .level_out(sdio_s));

    logic sclk_d_r, sclk_d_nxt;
    logic rise, fall;
    assign rise = sclk_s & ~sclk_d_r;
    assign fall = ~sclk_s & sclk_d_r;

    // ===========================================================
    // Register decode helpers
    logic [7:0] port_cfg_r, port_cfg_nxt;
    logic [7:0] rsvd_r, rsvd_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] upd_r, upd_nxt;
    logic [7:0] pwr_sh_r, pwr_sh_nxt, pwr_act_r, pwr_act_nxt;
    logic [7:0] stab_sh_r, stab_sh_nxt, stab_act_r, stab_act_nxt;
    logic [7:0] inset_sh_r, inset_sh_nxt, inset_act_r, inset_act_nxt;

    function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] pc, input logic [7:0] rs,
                                            input logic [7:0] mk, input logic [7:0] up, input logic [7:0] pw,
                                            input logic [7:0] st, input logic [7:0] is);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ADDR_PORT_CFG: d = pc;
            ADDR_CHIP_IDENTIFIER: d = CHIP_IDENTIFIER_VALUE;
            ADDR_RSVD_FLEX: d = rs;
            ADDR_CHAN_MASK: d = mk;
            ADDR_UPDATE: d = up;
            ADDR_POWER: d = pw;
            ADDR_STAB: d = st;
            ADDR_INSET: d = is;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // ===========================================================
    // Serial frame engine
    arm_state_t st_r, st_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] instr_r, instr_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [1:0] left_r, left_nxt;
    logic stream_r, stream_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic oe_r, oe_nxt;
    logic do_r, do_nxt;
    logic wr_stb;
    logic [7:0] wr_addr, wr_data;
    logic [7:0] rx_byte;
    logic lsbf;

    assign lsbf = port_cfg_r[BIT_LSBF_HI] | port_cfg_r[BIT_LSBF_LO];

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        instr_nxt = instr_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        left_nxt = left_r;
        stream_nxt = stream_r;
        tx_nxt = tx_r;
        oe_nxt = oe_r;
        do_nxt = do_r;
        wr_stb = 1'b0;
        wr_addr = addr_r;
        // LSB-first shifting already lands the first bit in bit 0, so no reversal
        rx_byte = lsbf ? {sdio_s, sh_r[7:1]} : {sh_r[6:0], sdio_s};
        wr_data = rx_byte;
        if (cs_n_s) begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            cnt_nxt = 5'h00;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    st_nxt = ST_INSTR;
                    cnt_nxt = 5'h00;
                end
                ST_INSTR: begin
                    if (rise) begin
                        instr_nxt = lsbf ? {sdio_s, instr_r[15:1]} : {instr_r[14:0], sdio_s};
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == 5'(INSTR_BITS - 1)) begin
                            st_nxt = ST_DATA;
                            cnt_nxt = 5'h00;
                        end
                    end
                end
                ST_DATA: begin
                    if (cnt_r == 5'h00 && st_r == ST_DATA && instr_r[BIT_RW] && !oe_r) begin
                        tx_nxt = read_reg(addr_r, port_cfg_r, rsvd_r, mask_r, upd_r, pwr_sh_r, stab_sh_r, inset_sh_r);
                    end
                    if (fall && instr_r[BIT_RW]) begin
                        oe_nxt = 1'b1;
                        do_nxt = lsbf ? tx_r[cnt_r[2:0]] : tx_r[3'h7 - cnt_r[2:0]];
                    end
                    if (rise) begin
                        sh_nxt = lsbf ? {sdio_s, sh_r[7:1]} : {sh_r[6:0], sdio_s};
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == 5'h07) begin
                            cnt_nxt = 5'h00;
                            oe_nxt = 1'b0;
                            wr_stb = !instr_r[BIT_RW];
                            addr_nxt = lsbf ? addr_r + 8'h01 : addr_r - 8'h01;
                            if (!stream_r) begin
                                if (left_r == 2'h0) begin
                                    st_nxt = ST_IDLE;
                                end
                                left_nxt = left_r - 2'h1;
                            end
                            tx_nxt = read_reg(addr_nxt, port_cfg_r, rsvd_r, mask_r, upd_r, pwr_sh_r, stab_sh_r,
                                              inset_sh_r);
                        end
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
        if (st_r == ST_INSTR && st_nxt == ST_DATA) begin
            addr_nxt = instr_nxt[7:0];
            left_nxt = instr_nxt[14:13];
            stream_nxt = (instr_nxt[14:13] == 2'h3);
            tx_nxt = read_reg(instr_nxt[7:0], port_cfg_r, rsvd_r, mask_r, upd_r, pwr_sh_r, stab_sh_r, inset_sh_r);
        end
    end

    // ===========================================================
    // Register file
    always_comb begin
        port_cfg_nxt = port_cfg_r;
        rsvd_nxt = rsvd_r;
        mask_nxt = mask_r;
        upd_nxt = upd_r;
        pwr_sh_nxt = pwr_sh_r;
        stab_sh_nxt = stab_sh_r;
        inset_sh_nxt = inset_sh_r;
        pwr_act_nxt = pwr_act_r;
        stab_act_nxt = stab_act_r;
        inset_act_nxt = inset_act_r;
        // Soft reset is self clearing, so hold it only one cycle
        if (port_cfg_r[BIT_SRST_HI] | port_cfg_r[BIT_SRST_LO]) begin
            port_cfg_nxt = RST_PORT_CFG;
        end
        if (upd_r[BIT_TRANSFER]) begin
            pwr_act_nxt = pwr_sh_r;
            stab_act_nxt = stab_sh_r;
            inset_act_nxt = inset_sh_r;
            upd_nxt = RST_UPDATE;
        end
        if (wr_stb) begin
            case (wr_addr)
                ADDR_PORT_CFG: port_cfg_nxt = (wr_data & PORT_CFG_WMASK) | PORT_CFG_FIXED;
                ADDR_RSVD_FLEX: rsvd_nxt = (rsvd_r & ~RSVD_WMASK) | (wr_data & RSVD_WMASK);
                ADDR_CHAN_MASK: mask_nxt = wr_data & MASK_WMASK;
                ADDR_UPDATE: upd_nxt = wr_data & 8'h01;
                ADDR_POWER: pwr_sh_nxt = wr_data & POWER_WMASK;
                ADDR_STAB: stab_sh_nxt = wr_data & STAB_WMASK;
                ADDR_INSET: inset_sh_nxt = wr_data & INSET_WMASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || soft_reset) begin
            port_cfg_r <= RST_PORT_CFG;
            rsvd_r <= RST_RSVD_FLEX;
            mask_r <= RST_CHAN_MASK;
            upd_r <= RST_UPDATE;
            pwr_sh_r <= RST_POWER;
            stab_sh_r <= RST_STAB;
            inset_sh_r <= RST_INSET;
            pwr_act_r <= RST_POWER;
            stab_act_r <= RST_STAB;
            inset_act_r <= RST_INSET;
        end else begin
            port_cfg_r <= port_cfg_nxt;
            rsvd_r <= rsvd_nxt;
            mask_r <= mask_nxt;
            upd_r <= upd_nxt;
            pwr_sh_r <= pwr_sh_nxt;
            stab_sh_r <= stab_sh_nxt;
            inset_sh_r <= inset_sh_nxt;
            pwr_act_r <= pwr_act_nxt;
            stab_act_r <= stab_act_nxt;
            inset_act_r <= inset_act_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sclk_d_r <= 1'b0;
            st_r <= ST_IDLE;
            cnt_r <= 5'h00;
            instr_r <= 16'h0000;
            sh_r <= 8'h00;
            addr_r <= 8'h00;
            left_r <= 2'h0;
            stream_r <= 1'b0;
            tx_r <= 8'h00;
            oe_r <= 1'b0;
            do_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_d_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            instr_r <= instr_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            left_r <= left_nxt;
            stream_r <= stream_nxt;
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
            do_r <= do_nxt;
        end
    end
    assign sclk_d_nxt = sclk_s;

    // ===========================================================
    // Active outputs
    function automatic logic [4:0] set_decode(input logic [3:0] sel);
        logic [4:0] m;
        m = 5'h00;
        case (sel[2:0])
            3'h0: m = 5'h01;
            3'h1: m = 5'h10;
            3'h2: m = 5'h03;
            3'h3: m = 5'h11;
            3'h4: m = 5'h07;
            3'h5: m = 5'h13;
            3'h6: m = 5'h0F;
            3'h7: m = 5'h17;
            default: m = 5'h01;
        endcase
        if (sel[3]) begin
            m = 5'h00;
        end
        return m;
    endfunction

    assign lsb_first = lsbf;
    assign soft_reset = port_cfg_r[BIT_SRST_HI] | port_cfg_r[BIT_SRST_LO];
    assign channel_write_mask = mask_r[3:0];
    assign power_state = pwr_act_r[1:0];
    assign powered_down = (pwr_act_r[1:0] == POWER_DOWN);
    assign chip_in_reset = (pwr_act_r[1:0] == POWER_RESET);
    assign stabilizer_en = stab_act_r[BIT_STAB_EN];
    assign input_set_select = inset_act_r[3:0];
    assign keep_unused_on = inset_act_r[BIT_KEEP_ON];
    // Unused inputs stay powered only when asked, otherwise only the selected set is on, or none when select bit 3 is set
    assign channels_active = keep_unused_on ? 5'h1F : set_decode(inset_act_r[3:0]);
    assign sdio_o = do_r;
    assign sdio_oe = oe_r;

    // ===========================================================
    // Checks
    AST_SHADOW_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
        (!upd_r[BIT_TRANSFER] && !soft_reset) |=> (stab_act_r == $past(stab_act_r)))
        else $error("active stage changed without transfer");
    AST_TRANSFER_COPY: assert property (@(posedge sys_clk) disable iff (srst)
        (upd_r[BIT_TRANSFER] && !soft_reset) |=> (inset_act_r == $past(inset_sh_r)))
        else $error("transfer did not copy shadow");
    AST_STAB_FOLLOW: assert property (@(posedge sys_clk) disable iff (srst)
        (upd_r[BIT_TRANSFER] && !stab_sh_r[BIT_STAB_EN] && !soft_reset) |=> !stabilizer_en)
        else $error("stabilizer stayed on after transfer of zero");
    AST_RESET_DEFAULTS: assert property (@(posedge sys_clk)
        srst |=> (port_cfg_r == RST_PORT_CFG && mask_r == RST_CHAN_MASK && stab_act_r == RST_STAB
                  && pwr_act_r == RST_POWER))
        else $error("reset defaults not loaded");
    AST_PORT_FIXED: assert property (@(posedge sys_clk) disable iff (srst)
        port_cfg_r[4:3] == 2'b11 && port_cfg_r[7] == 1'b0 && port_cfg_r[0] == 1'b0)
        else $error("port config fixed bits wrong");
    AST_MASK_UPPER: assert property (@(posedge sys_clk) disable iff (srst)
        mask_r[7:4] == 4'h0)
        else $error("channel mask upper bits set");
    AST_PD_DECODE: assert property (@(posedge sys_clk) disable iff (srst)
        powered_down |-> (power_state == 2'b01 && !chip_in_reset))
        else $error("power state decode wrong");
    AST_SET_A_ONLY: assert property (@(posedge sys_clk) disable iff (srst)
        (input_set_select == 4'h0 && !keep_unused_on) |-> channels_active == 5'h01)
        else $error("input set decode wrong");
    AST_TRANSFER_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
        (upd_r[BIT_TRANSFER] && !wr_stb) |=> !upd_r[BIT_TRANSFER])
        else $error("transfer bit did not self clear");
    AST_INSTR_LEN: assert property (@(posedge sys_clk) disable iff (srst)
        (st_r == ST_INSTR && st_nxt == ST_DATA) |-> cnt_r == 5'd15)
        else $error("instruction not 16 bits");
    COV_TRANSFER: cover property (@(posedge sys_clk) disable iff (srst) upd_r[BIT_TRANSFER]);
    COV_READ: cover property (@(posedge sys_clk) disable iff (srst) sdio_oe);
    COV_STAB_OFF: cover property (@(posedge sys_clk) disable iff (srst) !stabilizer_en);
    COV_SOFT_RESET: cover property (@(posedge sys_clk) disable iff (srst) soft_reset);
endmodule
`default_nettype wire

// [hdl/arm_pkg.sv]
// Purpose: Constants for the front-end configuration register bank
// Assumes: Serial frames of 16-bit instruction plus data bytes, addresses 8 bits wide
// Notes: Addresses and register words are eight bits wide
`default_nettype none
package arm_pkg;
    localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] ADDR_CHIP_IDENTIFIER = 8'h01;
    localparam logic [7:0] ADDR_RSVD_FLEX = 8'h04;
    localparam logic [7:0] ADDR_CHAN_MASK = 8'h05;
    localparam logic [7:0] ADDR_POWER = 8'h08;
    localparam logic [7:0] ADDR_STAB = 8'h09;
    localparam logic [7:0] ADDR_INSET = 8'h0C;
    localparam logic [7:0] ADDR_UPDATE = 8'hFF;
    localparam logic [7:0] RST_PORT_CFG = 8'h18;
    localparam logic [7:0] RST_RSVD_FLEX = 8'h0F;
    localparam logic [7:0] RST_CHAN_MASK = 8'h0F;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_STAB = 8'h01;
    localparam logic [7:0] RST_INSET = 8'h00;
    localparam logic [7:0] RST_UPDATE = 8'h00;
    // Arbitrary identification value
    localparam logic [7:0] CHIP_IDENTIFIER_VALUE = 8'h5C;
    localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
    localparam logic [7:0] PORT_CFG_WMASK = 8'h66;
    localparam logic [7:0] POWER_WMASK = 8'h03;
    localparam logic [7:0] STAB_WMASK = 8'h01;
    localparam logic [7:0] INSET_WMASK = 8'h4F;
    localparam logic [7:0] MASK_WMASK = 8'h0F;
    localparam logic [7:0] RSVD_WMASK = 8'h03;
    localparam int BIT_LSBF_HI = 6;
    localparam int BIT_LSBF_LO = 1;
    localparam int BIT_SRST_HI = 5;
    localparam int BIT_SRST_LO = 2;
    localparam int BIT_TRANSFER = 0;
    localparam int BIT_STAB_EN = 0;
    localparam int BIT_KEEP_ON = 6;
    localparam int INSTR_BITS = 16;
    localparam int BIT_RW = 15;
    localparam logic [1:0] POWER_RUN = 2'h0;
    localparam logic [1:0] POWER_DOWN = 2'h1;
    localparam logic [1:0] POWER_RESET = 2'h3;
    localparam logic [4:0] CHANS_SEL_WIDTH = 5'h05;
    localparam logic [3:0] NUM_IN_SETS = 4'h8;
endpackage
`default_nettype wire

// [hdl/arm_pin_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to sys_clk
// Notes: Output moves only when stages two and three agree
`default_nettype none
module arm_pin_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level_out
);
    logic s1_r, s2_r, s3_r, lvl_r;
    logic lvl_nxt;
    always_comb begin
        lvl_nxt = lvl_r;
        if (s2_r == s3_r) begin
            lvl_nxt = s3_r;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end
    assign level_out = lvl_r;
endmodule
`default_nettype wire

// [verif/arm_host.sv]
// Purpose: Serial-port host model that frames register accesses into the bank
// Assumes: Mode 0; clock idles low and stands still between frames
// Notes: Half period 160 ns; a released data line toggles so it never mimics a driven bit
`default_nettype none
module arm_host (
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic host_val,
    // Resolved data line
    input wire logic sdio
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_val = 1'b0;
    end

    // ==========================================
    // Frame: 16-bit instruction then one byte; cut ends it early
    task automatic frame(input logic rd, input logic lsbf, input logic [7:0] addr, input logic [7:0] wd,
                         input int cut, output logic [7:0] rdv);
        logic [23:0] bits;
        int pos;
        bits = {rd, 2'h0, 5'h00, addr, wd};
        rdv = 8'h00;
        cs_n = 1'b0;
        #160;
        for (int i = 0; i < cut; i++) begin
            pos = lsbf ? (i < 16 ? 8 + i : i - 16) : 23 - i;
            host_val = (rd && i >= 16) ? ~host_val : bits[pos];
            #160 sclk = 1'b1;
            // Late sample: the pin synchroniser delays read data by several clocks
            #140 if (rd && i >= 16) rdv[pos] = sdio;
            #20 sclk = 1'b0;
        end
        #160 cs_n = 1'b1;
        host_val = ~host_val;
        #320;
    endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench for the shadowed register bank
// Assumes: Host model drives frames off the system clock edges
// Notes: Shadowed writes are first checked as held on the active outputs, then moved there by a transfer write
`default_nettype none
module tb import arm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================
    // Signals
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic sclk, cs_n, host_val, sdio_w, sdio_o, sdio_oe, lsb_first, soft_reset;
    logic [3:0] channel_write_mask;
    logic [1:0] power_state;
    logic powered_down, chip_in_reset, stabilizer_en, keep_unused_on;
    logic [3:0] input_set_select;
    logic [4:0] channels_active;
    int n_fail = 0;
    int n_compared = 0;
    int n_srst = 0;
    logic lf = 1'b0;
    logic [7:0] v;
    typedef struct packed {logic [7:0] a, dflt, wd, rb;} arm_row_t;
    arm_row_t rows [9] = '{32'h00181818, 32'h015CFF5C, 32'h040F000C, 32'h050F0A0A, 32'h08000101,
                           32'h09010000, 32'h0C004545, 32'hFF000000, 32'h30000000};
    logic [4:0] mux_exp [9] = '{5'h01, 5'h10, 5'h03, 5'h11, 5'h07, 5'h13, 5'h0F, 5'h17, 5'h00};

    always #20 sys_clk = ~sys_clk;
    assign sdio_w = sdio_oe ? sdio_o : host_val;
    always @(posedge sys_clk) if (soft_reset === 1'b1) n_srst++;

    arm_regbank i_arm_regbank (.sys_clk(sys_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_w),
        .sdio_o(sdio_o), .sdio_oe(sdio_oe), .lsb_first(lsb_first), .soft_reset(soft_reset),
        .channel_write_mask(channel_write_mask), .power_state(power_state), .powered_down(powered_down),
        .chip_in_reset(chip_in_reset), .stabilizer_en(stabilizer_en), .input_set_select(input_set_select),
        .keep_unused_on(keep_unused_on), .channels_active(channels_active));
    arm_host i_arm_host (.sclk(sclk), .cs_n(cs_n), .host_val(host_val), .sdio(sdio_w));

    // ==========================================
    // Tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int cut = 24);
        logic [7:0] unused;
        i_arm_host.frame(1'b0, lf, a, d, cut, unused);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_arm_host.frame(1'b1, lf, a, 8'h00, 24, d);
    endtask
    task automatic give_verdict;
        $display("counts: compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #13;
        foreach (rows[k]) begin
            rd(rows[k].a, v);
            chk("default", rows[k].dflt, v);
            wr(rows[k].a, rows[k].wd);
            rd(rows[k].a, v);
            chk("readback", rows[k].rb, v);
        end
        $display("test table done");
        chk("mask", 8'h0A, {4'h0, channel_write_mask});
        chk("held", 8'h20, {power_state, stabilizer_en, keep_unused_on, input_set_select});
        wr(ADDR_UPDATE, 8'h01);
        chk("moved", 8'h55, {power_state, stabilizer_en, keep_unused_on, input_set_select});
        chk("decode", 8'h9F, {powered_down, chip_in_reset, 1'b0, channels_active});
        rd(ADDR_UPDATE, v);
        chk("transfer", 8'h00, v);
        $display("test transfer done");
        wr(ADDR_STAB, 8'h01, 20);
        rd(ADDR_STAB, v);
        chk("abort", 8'h00, v);
        $display("test abort done");
        for (int c = 0; c < 9; c++) begin
            wr(ADDR_INSET, 8'(c));
            wr(ADDR_UPDATE, 8'h01);
            chk("mux", {3'h0, mux_exp[c]}, {3'h0, channels_active});
        end
        wr(ADDR_POWER, 8'h03);
        wr(ADDR_UPDATE, 8'h01);
        chk("reset_mode", 8'h07, {4'h0, powered_down, chip_in_reset, power_state});
        // Leaving the reset mode takes the same transfer as any other setting
        wr(ADDR_POWER, 8'h00);
        wr(ADDR_UPDATE, 8'h01);
        chk("run_mode", 8'h00, {4'h0, powered_down, chip_in_reset, power_state});
        $display("test modes done");
        // Bits 4 and 3 kept set while toggling the mirrored order bits
        wr(ADDR_PORT_CFG, 8'h5A);
        chk("lsbf", 8'h01, {7'h00, lsb_first});
        lf = 1'b1;
        rd(ADDR_CHAN_MASK, v);
        chk("lsbf_read", 8'h0A, v);
        // An asymmetric byte shows the write data order, not only the instruction order
        wr(ADDR_CHAN_MASK, 8'h03);
        chk("lsbf_write", 8'h03, {4'h0, channel_write_mask});
        wr(ADDR_PORT_CFG, 8'h18);
        lf = 1'b0;
        chk("msbf", 8'h00, {7'h00, lsb_first});
        $display("test order done");
        wr(ADDR_PORT_CFG, 8'h3C);
        chk("soft_pulses", 8'h01, 8'(n_srst));
        rd(ADDR_CHAN_MASK, v);
        chk("soft_mask", 8'h0F, v);
        rd(ADDR_PORT_CFG, v);
        chk("soft_cfg", 8'h18, v);
        chk("soft_active", 8'h20, {power_state, stabilizer_en, keep_unused_on, input_set_select});
        chk("soft_chans", 8'h01, {powered_down, chip_in_reset, 1'b0, channels_active});
        $display("test soft reset done");
        give_verdict();
    end

    // Hang guard
    initial begin
        for (int k = 0; k < 60000; k++) @(posedge sys_clk);
        n_fail++;
        $display("mismatch run_end exp finished got hang");
        give_verdict();
    end
endmodule
`default_nettype wire
